// ==== common/enclave_init_pkg.sv ====
// Package for the enclave initialization validator: register map, codes, field types
package enclave_init_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_LEAF       = 8'h00;
	localparam logic [7:0] OFF_DESC_ADDR  = 8'h04;
	localparam logic [7:0] OFF_CTRL_ADDR  = 8'h08;
	localparam logic [7:0] OFF_TOKEN_ADDR = 8'h0c;
	localparam logic [7:0] OFF_COMMAND    = 8'h10;
	localparam logic [7:0] OFF_RESULT     = 8'h14;
	localparam logic [7:0] OFF_FLAGS      = 8'h18;
	localparam logic [7:0] OFF_STATUS     = 8'h1c;

	localparam logic [31:0] LEAF_INIT  = 32'h0000_0002;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	// Result codes; values are arbitrary but distinct
	localparam logic [31:0] CODE_OK               = 32'h0000_0000;
	localparam logic [31:0] CODE_BAD_DESCRIPTOR   = 32'h0000_0001;
	localparam logic [31:0] CODE_BAD_ATTR         = 32'h0000_0002;
	localparam logic [31:0] CODE_BAD_MEASURE      = 32'h0000_0003;
	localparam logic [31:0] CODE_BAD_SIGNATURE    = 32'h0000_0004;
	localparam logic [31:0] CODE_BAD_LICENCE      = 32'h0000_0005;
	localparam logic [31:0] CODE_BAD_CORE_VERSION = 32'h0000_0006;
	localparam logic [31:0] CODE_EVENT_ABORT      = 32'h0000_0007;

	// Flag bit positions in the flags register
	localparam int FLAG_CARRY  = 0;
	localparam int FLAG_PARITY = 2;
	localparam int FLAG_AUX    = 4;
	localparam int FLAG_ZERO   = 6;
	localparam int FLAG_SIGN   = 7;
	localparam int FLAG_OVER   = 11;
	localparam logic [11:0] FLAGS_CLEARED = 12'h895;

	// Status bit positions
	localparam int ST_BUSY     = 0;
	localparam int ST_INIT     = 1;
	localparam int ST_GP_FAULT = 2;
	localparam int ST_DONE     = 3;

	// Attribute layout
	localparam logic [63:0] ATTR_CONTROLLED = 64'h0000_0000_0000_0020;
	localparam logic [63:0] ATTR_RESERVED   = 64'hffff_ffff_ffff_ffc0;
	localparam int          ATTR_DEBUG      = 1;

	localparam logic [11:0] ALIGN_PAGE_MASK  = 12'hfff;
	localparam logic [8:0]  ALIGN_TOKEN_MASK = 9'h1ff;

	typedef struct packed {
		logic         sigValid;
		logic [63:0]  attributes;
		logic [63:0]  attrSelectMask;
		logic [255:0] descriptorMeasurement;
		logic [255:0] modulusDigest;
		logic [15:0]  productSecurityVersion;
		logic [15:0]  productIdentifier;
	} signed_descriptor_t;

	typedef struct packed {
		logic [63:0]  attributes;
		logic [255:0] finalMeasurement;
	} enclave_control_struct_t;

	typedef struct packed {
		logic         valid;
		logic         debugAttr;
		logic         contentOk;
		logic         versionOk;
		logic [255:0] measurement;
	} launch_token_t;

	typedef struct packed {
		logic extInt;
		logic extInhibit;
		logic nmi;
		logic smi;
		logic machineCheck;
		logic initSignal;
		logic preemptTimer;
	} async_events_t;

	// Other operations that are busy on the same control structure
	typedef struct packed {
		logic enclaveExitOp;
		logic pageAddOp;
		logic enclaveCreateOp;
		logic enclaveEntryOp;
		logic measureExtendOp;
		logic otherInitOp;
		logic pageBlockOp;
	} concurrent_ops_t;

	typedef struct packed {
		logic         initialized;
		logic [255:0] enclaveMeasurement;
		logic [255:0] signerIdentity;
		logic [15:0]  productSecurityVersion;
		logic [15:0]  productIdentifier;
	} commit_t;

	typedef struct packed {
		logic        active;
		logic [31:0] descAddr;
		logic [31:0] ctrlAddr;
		logic [31:0] tokenAddr;
		logic        descEnclave;
		logic        ctrlEnclaveRw;
		logic        tokenEnclave;
	} mem_access_t;

endpackage : enclave_init_pkg

// ==== verilog/enclave_init_validator.sv ====
// Enclave initialization validator with AXI4-Lite register access
`timescale 1ns/10ps
`default_nettype none

module enclave_init_validator (
	input  wire logic                                     ref_clk,
	input  wire logic                                     srst,
	input  wire logic [7:0]                               s_axi_awaddr,
	input  wire logic                                     s_axi_awvalid,
	output logic                                          s_axi_awready,
	input  wire logic [31:0]                              s_axi_wdata,
	input  wire logic [3:0]                               s_axi_wstrb,
	input  wire logic                                     s_axi_wvalid,
	output logic                                          s_axi_wready,
	output logic [1:0]                                    s_axi_bresp,
	output logic                                          s_axi_bvalid,
	input  wire logic                                     s_axi_bready,
	input  wire logic [7:0]                               s_axi_araddr,
	input  wire logic                                     s_axi_arvalid,
	output logic                                          s_axi_arready,
	output logic [31:0]                                   s_axi_rdata,
	output logic [1:0]                                    s_axi_rresp,
	output logic                                          s_axi_rvalid,
	input  wire logic                                     s_axi_rready,
	input  wire enclave_init_pkg::signed_descriptor_t     descriptor,
	input  wire enclave_init_pkg::enclave_control_struct_t controlStruct,
	input  wire enclave_init_pkg::launch_token_t          launchToken,
	input  wire logic [255:0]                             launchKeyHashReg,
	input  wire enclave_init_pkg::async_events_t          events,
	input  wire enclave_init_pkg::concurrent_ops_t        concurrentOps,
	output enclave_init_pkg::commit_t                     commitOut,
	output enclave_init_pkg::mem_access_t                 memAccess,
	output logic                                          retirePulse
);

	typedef enum logic [5:0] {
		S_IDLE   = 6'h01,
		S_SIG    = 6'h02,
		S_MEAS   = 6'h04,
		S_ATTR   = 6'h08,
		S_TOKEN  = 6'h10,
		S_COMMIT = 6'h20
	} state_t;

	state_t                    stateReg;
	logic [31:0]               leafReg;
	logic [31:0]               descAddrReg;
	logic [31:0]               ctrlAddrReg;
	logic [31:0]               tokenAddrReg;
	logic [31:0]               resultReg;
	logic [11:0]               flagsReg;
	logic                      gpFaultReg;
	logic                      doneReg;
	enclave_init_pkg::commit_t commitReg;
	logic                      retireReg;
	logic                      awHeld;
	logic                      wHeld;
	logic [7:0]                awAddrReg;
	logic [31:0]               wDataReg;
	logic [3:0]                wStrbReg;
	logic                      bValidReg;
	logic [1:0]                bRespReg;
	logic                      rValidReg;
	logic [31:0]               rDataReg;
	logic [1:0]                rRespReg;

	logic        writeFire;
	logic        readFire;
	logic        cmdFire;
	logic        aligned;
	logic        conflict;
	logic        eventPending;
	logic        running;
	logic        keyMatch;
	logic        startOk;
	logic [31:0] failCode;
	logic        failNow;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

	function automatic logic mapped(input logic [7:0] addr);
		return (addr[1:0] == 2'h0) && (addr <= enclave_init_pkg::OFF_STATUS);
	endfunction : mapped

	// Bus slave: address and data may arrive in either order
	assign s_axi_awready = !awHeld && !bValidReg;
	assign s_axi_wready  = !wHeld && !bValidReg;
	assign s_axi_bvalid  = bValidReg;
	assign s_axi_bresp   = bRespReg;
	assign s_axi_arready = !rValidReg;
	assign s_axi_rvalid  = rValidReg;
	assign s_axi_rdata   = rDataReg;
	assign s_axi_rresp   = rRespReg;
	assign writeFire     = awHeld && wHeld && !bValidReg;
	assign readFire      = s_axi_arvalid && !rValidReg;
	assign cmdFire       = writeFire && (awAddrReg == enclave_init_pkg::OFF_COMMAND)
		&& wStrbReg[0] && wDataReg[0];

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			awHeld    <= 1'b0;
			wHeld     <= 1'b0;
			awAddrReg <= 8'h00;
			wDataReg  <= 32'h0000_0000;
			wStrbReg  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld    <= 1'b1;
				awAddrReg <= s_axi_awaddr;
			end else if (writeFire) begin
				awHeld <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld    <= 1'b1;
				wDataReg <= s_axi_wdata;
				wStrbReg <= s_axi_wstrb;
			end else if (writeFire) begin
				wHeld <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			bValidReg <= 1'b0;
			bRespReg  <= 2'h0;
		end else if (writeFire) begin
			bValidReg <= 1'b1;
			bRespReg  <= mapped(awAddrReg) ? 2'h0 : 2'h2;
		end else if (s_axi_bready) begin
			bValidReg <= 1'b0;
		end
	end

	// Address registers only change while idle so a run sees stable operands
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			leafReg      <= enclave_init_pkg::RESET_WORD;
			descAddrReg  <= enclave_init_pkg::RESET_WORD;
			ctrlAddrReg  <= enclave_init_pkg::RESET_WORD;
			tokenAddrReg <= enclave_init_pkg::RESET_WORD;
		end else if (writeFire && stateReg == S_IDLE) begin
			case (awAddrReg)
				enclave_init_pkg::OFF_LEAF: begin
					leafReg <= merge_bytes(leafReg, wDataReg, wStrbReg);
				end
				enclave_init_pkg::OFF_DESC_ADDR: begin
					descAddrReg <= merge_bytes(descAddrReg, wDataReg, wStrbReg);
				end
				enclave_init_pkg::OFF_CTRL_ADDR: begin
					ctrlAddrReg <= merge_bytes(ctrlAddrReg, wDataReg, wStrbReg);
				end
				enclave_init_pkg::OFF_TOKEN_ADDR: begin
					tokenAddrReg <= merge_bytes(tokenAddrReg, wDataReg, wStrbReg);
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rValidReg <= 1'b0;
			rDataReg  <= 32'h0000_0000;
			rRespReg  <= 2'h0;
		end else if (readFire) begin
			rValidReg <= 1'b1;
			rRespReg  <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
			case (s_axi_araddr)
				enclave_init_pkg::OFF_LEAF:       rDataReg <= leafReg;
				enclave_init_pkg::OFF_DESC_ADDR:  rDataReg <= descAddrReg;
				enclave_init_pkg::OFF_CTRL_ADDR:  rDataReg <= ctrlAddrReg;
				enclave_init_pkg::OFF_TOKEN_ADDR: rDataReg <= tokenAddrReg;
				enclave_init_pkg::OFF_RESULT:     rDataReg <= resultReg;
				enclave_init_pkg::OFF_FLAGS:      rDataReg <= {20'h00000, flagsReg};
				enclave_init_pkg::OFF_STATUS: begin
					rDataReg <= {28'h0000000, doneReg, gpFaultReg, commitReg.initialized,
						running};
				end
				default:                          rDataReg <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			rValidReg <= 1'b0;
		end
	end

	// Start qualification
	assign aligned = ((descAddrReg[11:0] & enclave_init_pkg::ALIGN_PAGE_MASK) == 12'h000)
		&& ((ctrlAddrReg[11:0] & enclave_init_pkg::ALIGN_PAGE_MASK) == 12'h000)
		&& ((tokenAddrReg[8:0] & enclave_init_pkg::ALIGN_TOKEN_MASK) == 9'h000);
	// Page block is deliberately absent from the conflict set
	assign conflict = concurrentOps.enclaveExitOp | concurrentOps.pageAddOp
		| concurrentOps.enclaveCreateOp | concurrentOps.enclaveEntryOp
		| concurrentOps.measureExtendOp | concurrentOps.otherInitOp;
	assign startOk  = cmdFire && (stateReg == S_IDLE)
		&& (leafReg == enclave_init_pkg::LEAF_INIT);

	assign eventPending = (events.extInt && !events.extInhibit)
		| events.nmi | events.smi | events.machineCheck
		| events.initSignal | events.preemptTimer;
	assign running  = (stateReg != S_IDLE);
	assign keyMatch = (descriptor.modulusDigest == launchKeyHashReg);

	// First failing check of the current stage, in documented priority
	always_comb begin
		failNow  = 1'b0;
		failCode = enclave_init_pkg::CODE_OK;
		case (stateReg)
			S_SIG: begin
				if (!descriptor.sigValid) begin
					failNow  = 1'b1;
					failCode = enclave_init_pkg::CODE_BAD_SIGNATURE;
				end
			end
			S_MEAS: begin
				if (controlStruct.finalMeasurement != descriptor.descriptorMeasurement) begin
					failNow  = 1'b1;
					failCode = enclave_init_pkg::CODE_BAD_MEASURE;
				end
			end
			S_ATTR: begin
				if (((descriptor.attributes & enclave_init_pkg::ATTR_RESERVED) != 64'h0)
					|| ((~descriptor.attrSelectMask & enclave_init_pkg::ATTR_RESERVED)
					!= 64'h0)) begin
					failNow  = 1'b1;
					failCode = enclave_init_pkg::CODE_BAD_DESCRIPTOR;
				end else if (((descriptor.attributes & enclave_init_pkg::ATTR_CONTROLLED)
					!= 64'h0) && !keyMatch) begin
					failNow  = 1'b1;
					failCode = enclave_init_pkg::CODE_BAD_ATTR;
				end else if (descriptor.attributes
					!= (descriptor.attrSelectMask & controlStruct.attributes)) begin
					failNow  = 1'b1;
					failCode = enclave_init_pkg::CODE_BAD_ATTR;
				end
			end
			S_TOKEN: begin
				if (!launchToken.valid) begin
					if (!keyMatch) begin
						failNow  = 1'b1;
						failCode = enclave_init_pkg::CODE_BAD_LICENCE;
					end
				end else if (launchToken.debugAttr
					&& !controlStruct.attributes[enclave_init_pkg::ATTR_DEBUG]) begin
					failNow  = 1'b1;
					failCode = enclave_init_pkg::CODE_BAD_LICENCE;
				end else if (!launchToken.contentOk) begin
					failNow  = 1'b1;
					failCode = enclave_init_pkg::CODE_BAD_LICENCE;
				end else if (launchToken.measurement != controlStruct.finalMeasurement) begin
					failNow  = 1'b1;
					failCode = enclave_init_pkg::CODE_BAD_MEASURE;
				end else if (!launchToken.versionOk) begin
					failNow  = 1'b1;
					failCode = enclave_init_pkg::CODE_BAD_CORE_VERSION;
				end
			end
			default: begin
			end
		endcase
	end

	// Sequencer; events are polled in every checking stage, never during commit
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			stateReg <= S_IDLE;
		end else begin
			case (stateReg)
				S_IDLE: begin
					if (startOk && aligned && !conflict) begin
						stateReg <= S_SIG;
					end
				end
				S_SIG, S_MEAS, S_ATTR: begin
					if (eventPending || failNow) begin
						stateReg <= S_IDLE;
					end else if (stateReg == S_SIG) begin
						stateReg <= S_MEAS;
					end else if (stateReg == S_MEAS) begin
						stateReg <= S_ATTR;
					end else begin
						stateReg <= S_TOKEN;
					end
				end
				S_TOKEN: begin
					stateReg <= (eventPending || failNow) ? S_IDLE : S_COMMIT;
				end
				S_COMMIT: stateReg <= S_IDLE;
				default:  stateReg <= S_IDLE;
			endcase
		end
	end

	// Result, flags and retirement
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			resultReg <= enclave_init_pkg::CODE_OK;
			flagsReg  <= 12'h000;
			retireReg <= 1'b0;
			doneReg   <= 1'b0;
		end else begin
			retireReg <= 1'b0;
			if (startOk) begin
				doneReg <= 1'b0;
			end
			if (running && stateReg != S_COMMIT && (eventPending || failNow)) begin
				resultReg <= eventPending ? enclave_init_pkg::CODE_EVENT_ABORT
					: failCode;
				flagsReg  <= (flagsReg & ~enclave_init_pkg::FLAGS_CLEARED)
					| (12'h001 << enclave_init_pkg::FLAG_ZERO);
				retireReg <= 1'b1;
				doneReg   <= 1'b1;
			end else if (stateReg == S_COMMIT) begin
				resultReg <= enclave_init_pkg::CODE_OK;
				flagsReg  <= flagsReg & ~(enclave_init_pkg::FLAGS_CLEARED
					| (12'h001 << enclave_init_pkg::FLAG_ZERO));
				retireReg <= 1'b1;
				doneReg   <= 1'b1;
			end
		end
	end

	// A fault leaves result and flags untouched, as a faulting instruction would
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			gpFaultReg <= 1'b0;
		end else if (startOk) begin
			gpFaultReg <= !aligned || conflict;
		end
	end

	// Identity fields are written only from the commit stage
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			commitReg <= '0;
		end else if (stateReg == S_COMMIT) begin
			commitReg.initialized            <= 1'b1;
			commitReg.enclaveMeasurement     <= controlStruct.finalMeasurement;
			commitReg.signerIdentity         <= descriptor.modulusDigest;
			commitReg.productSecurityVersion <= descriptor.productSecurityVersion;
			commitReg.productIdentifier      <= descriptor.productIdentifier;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			memAccess <= '0;
		end else begin
			memAccess.active        <= running;
			memAccess.descAddr      <= descAddrReg;
			memAccess.ctrlAddr      <= ctrlAddrReg;
			memAccess.tokenAddr     <= tokenAddrReg;
			memAccess.descEnclave   <= 1'b0;
			memAccess.ctrlEnclaveRw <= 1'b1;
			memAccess.tokenEnclave  <= 1'b0;
		end
	end

	assign commitOut   = commitReg;
	assign retirePulse = retireReg;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	a_leaf_start: assert property (startOk && aligned && !conflict |=> stateReg == S_SIG)
		else $error("valid start did not enter signature stage");
	a_align_fault: assert property (startOk && !aligned |=> gpFaultReg && stateReg == S_IDLE)
		else $error("misaligned start not faulted");
	a_conflict_fault: assert property (startOk && conflict |=> gpFaultReg && !running)
		else $error("conflicting start not refused");
	a_event_abort: assert property (running && stateReg != S_COMMIT && eventPending |=> retirePulse && resultReg == enclave_init_pkg::CODE_EVENT_ABORT && flagsReg[enclave_init_pkg::FLAG_ZERO])
		else $error("event abort not reported");
	a_sig_fail: assert property (stateReg == S_SIG && !eventPending && !descriptor.sigValid |=> resultReg == enclave_init_pkg::CODE_BAD_SIGNATURE && stateReg == S_IDLE)
		else $error("bad signature not reported");
	a_meas_fail: assert property (stateReg == S_MEAS && !eventPending && controlStruct.finalMeasurement != descriptor.descriptorMeasurement |=> resultReg == enclave_init_pkg::CODE_BAD_MEASURE)
		else $error("bad measurement not reported");
	a_flags_clear: assert property (retirePulse |-> (flagsReg & enclave_init_pkg::FLAGS_CLEARED) == 12'h000)
		else $error("arithmetic flags not cleared");
	a_success_zero: assert property (retirePulse && !flagsReg[enclave_init_pkg::FLAG_ZERO] |-> resultReg == enclave_init_pkg::CODE_OK && commitReg.initialized)
		else $error("success without zero result");
	a_commit_guard: assert property ($changed(commitReg) |-> $past(stateReg) == S_COMMIT && resultReg == enclave_init_pkg::CODE_OK)
		else $error("identity changed outside commit");
	a_token_debug: assert property (stateReg == S_TOKEN && !eventPending && launchToken.valid && launchToken.debugAttr && !controlStruct.attributes[enclave_init_pkg::ATTR_DEBUG] |=> resultReg == enclave_init_pkg::CODE_BAD_LICENCE)
		else $error("debug token launched production enclave");
	a_run_length: assert property (startOk && aligned && !conflict |-> ##[2:6] retirePulse)
		else $error("run did not retire in time");

	c_success: cover property (stateReg == S_COMMIT ##1 retirePulse);
	c_event: cover property (running && eventPending ##1 retirePulse);
	c_gp_fault: cover property (startOk && !aligned);
	c_token_fail: cover property (stateReg == S_TOKEN && failNow);

endmodule : enclave_init_validator

`default_nettype wire

// ==== sim/enclave_memory_model.sv ====
// Software and memory model supplying the operands of one initialization
`timescale 1ns/10ps
`default_nettype none
module enclave_memory_model (
	input  wire logic [3:0]                          caseSel,
	input  wire logic [31:0]                         rnd,
	output enclave_init_pkg::signed_descriptor_t     descriptor,
	output enclave_init_pkg::enclave_control_struct_t controlStruct,
	output enclave_init_pkg::launch_token_t          launchToken,
	output logic [255:0]                             launchKeyHashReg
);
	logic [255:0] meas;
	logic [63:0]  attr;
	assign meas = {8{rnd}};
	// Case 6 drops the controlled bit, case 7 the debug bit
	assign attr = (caseSel == 4'h6) ? 64'h2 : (caseSel == 4'h7) ? 64'h20 : 64'h22;
	always_comb begin
		launchKeyHashReg = ~meas;
		controlStruct = {attr, meas};
		descriptor.sigValid = caseSel != 4'h1;
		descriptor.attributes = attr | ((caseSel == 4'h3) ? 64'h40 : {63'h0, caseSel == 4'h5});
		descriptor.attrSelectMask = '1;
		descriptor.descriptorMeasurement = (caseSel == 4'h2) ? ~meas : meas;
		descriptor.modulusDigest = (caseSel == 4'h4 || caseSel == 4'h6) ? meas : ~meas;
		descriptor.productSecurityVersion = rnd[15:0];
		descriptor.productIdentifier = rnd[31:16];
		launchToken = {caseSel > 4'h6, 1'h1, caseSel != 4'h8, caseSel != 4'ha,
			(caseSel == 4'h9) ? ~meas : meas};
	end
endmodule : enclave_memory_model
`default_nettype wire

// ==== sim/enclave_init_validator_tb.sv ====
// Self-checking bench for the enclave initialization validator
`timescale 1ns/10ps
`default_nettype none
module enclave_init_validator_tb;
	localparam logic [31:0] GP = 32'hffff_ffff;
	localparam logic [31:0] NONE = 32'hffff_fffe;
	logic ref_clk = 1'h0, srst = 1'h1;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf, caseSel = 4'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, retirePulse;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [255:0] launchKeyHashReg;
	logic [31:0] codes [12] = '{32'h0, 32'h4, 32'h3, 32'h1, 32'h2, 32'h2,
		32'h5, 32'h5, 32'h5, 32'h3, 32'h6, 32'h0};
	enclave_init_pkg::signed_descriptor_t descriptor;
	enclave_init_pkg::enclave_control_struct_t controlStruct;
	enclave_init_pkg::launch_token_t launchToken;
	enclave_init_pkg::async_events_t events = '0;
	enclave_init_pkg::concurrent_ops_t concurrentOps = '0;
	enclave_init_pkg::commit_t commitOut, expCommit = '0;
	enclave_init_pkg::mem_access_t memAccess;
	int err_count = 0, checks = 0;
	always #2 ref_clk = ~ref_clk;
	enclave_init_validator i_enclave_init_validator (.ref_clk, .srst, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .descriptor, .controlStruct, .launchToken, .launchKeyHashReg,
		.events, .concurrentOps, .commitOut, .memAccess, .retirePulse);
	enclave_memory_model i_enclave_memory_model (.caseSel, .rnd, .descriptor, .controlStruct,
		.launchToken, .launchKeyHashReg);
	task automatic final_report();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	task automatic hang();
		err_count++;
		final_report();
	endtask : hang
	task automatic cmp_word(input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: exp %h got %h", $time, exp, got);
		end
	endtask : cmp_word
	task automatic cmp_commit();
		checks++;
		if (commitOut !== expCommit) begin
			err_count++;
			$display("unexpected at %0t: exp %h got %h", $time, expCommit, commitOut);
		end
	endtask : cmp_commit
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic aw, w, b;
		logic [1:0] r;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(negedge ref_clk);
			aw = s_axi_awready;
			w = s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge ref_clk);
			if (aw) s_axi_awvalid <= 1'h0;
			if (w) s_axi_wvalid <= 1'h0;
			if (b) break;
		end
		if (n == 40) hang();
		s_axi_bready <= 1'h0;
		cmp_word({30'h0, er}, {30'h0, r});
	endtask : axi_write
	task automatic axi_read(input logic [7:0] a, input logic [1:0] er, output logic [31:0] got);
		int n;
		logic ar, b;
		logic [1:0] r;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(negedge ref_clk);
			ar = s_axi_arready;
			b = s_axi_rvalid;
			got = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge ref_clk);
			if (ar) s_axi_arvalid <= 1'h0;
			if (b) break;
		end
		if (n == 40) hang();
		s_axi_rready <= 1'h0;
		cmp_word({30'h0, er}, {30'h0, r});
	endtask : axi_read
	task automatic run_case(input logic [3:0] c, input logic [6:0] ev, input logic [6:0] op,
		input logic [31:0] dA, input logic [31:0] tA, input logic [31:0] exp);
		int n;
		logic [31:0] seen, got;
		@(posedge ref_clk);
		caseSel <= c;
		rnd <= $urandom;
		events <= ev;
		concurrentOps <= op;
		axi_write(enclave_init_pkg::OFF_DESC_ADDR, dA, 2'h0);
		axi_write(enclave_init_pkg::OFF_CTRL_ADDR, 32'h2000, 2'h0);
		axi_write(enclave_init_pkg::OFF_TOKEN_ADDR, tA, 2'h0);
		axi_write(enclave_init_pkg::OFF_COMMAND, 32'h1, 2'h0);
		seen = 32'h0;
		for (n = 0; n < 12; n++) begin
			@(negedge ref_clk);
			seen += {31'h0, retirePulse};
			if (memAccess.active) cmp_word(32'h2, {29'h0, memAccess[2:0]});
			if (memAccess.active) cmp_word(dA, memAccess.descAddr);
			if (memAccess.active) cmp_word(tA, memAccess.tokenAddr);
		end
		cmp_word({31'h0, exp < 32'h8}, seen);
		if (exp < 32'h8) begin
			if (exp == 32'h0) expCommit = {1'h1, {8{rnd}}, {8{~rnd}}, rnd[15:0], rnd[31:16]};
			axi_read(enclave_init_pkg::OFF_RESULT, 2'h0, got);
			cmp_word(exp, got);
			axi_read(enclave_init_pkg::OFF_FLAGS, 2'h0, got);
			cmp_word({25'h0, exp != 32'h0, 6'h0}, got & 32'h8d5);
			axi_read(enclave_init_pkg::OFF_STATUS, 2'h0, got);
			cmp_word({28'h0, 2'h2, expCommit.initialized, 1'h0}, got);
		end else if (exp == GP) begin
			axi_read(enclave_init_pkg::OFF_STATUS, 2'h0, got);
			cmp_word(32'h1, {31'h0, got[enclave_init_pkg::ST_GP_FAULT]});
		end
		cmp_commit();
	endtask : run_case
	initial begin
		int i;
		logic [31:0] got;
		got = $urandom(32'he607d651);
		repeat (2) @(posedge ref_clk);
		srst <= 1'h0;
		axi_read(enclave_init_pkg::OFF_RESULT, 2'h0, got);
		cmp_word(32'h0, got);
		axi_read(8'h20, 2'h2, got);
		cmp_word(32'h0, got);
		axi_write(8'h22, 32'h1, 2'h2);
		axi_write(enclave_init_pkg::OFF_LEAF, 32'h3, 2'h0);
		run_case(4'h0, 7'h0, 7'h0, 32'h1000, 32'h600, NONE);
		@(posedge ref_clk);
		s_axi_wstrb <= 4'h1;
		axi_write(enclave_init_pkg::OFF_LEAF, 32'hffff_ff02, 2'h0);
		s_axi_wstrb <= 4'hf;
		axi_read(enclave_init_pkg::OFF_LEAF, 2'h0, got);
		cmp_word(32'h2, got);
		for (i = 0; i < 12; i++) run_case(i[3:0], 7'h0, 7'h0, 32'h1000, 32'h600, codes[i]);
		for (i = 0; i < 7; i++) run_case(4'hb, 7'(1 << i), 7'h0, 32'h1000, 32'h600, (i == 5) ? 32'h0 : 32'h7);
		run_case(4'h0, 7'h60, 7'h0, 32'h1000, 32'h600, 32'h0);
		for (i = 0; i < 7; i++) run_case(4'hb, 7'h0, 7'(1 << i), 32'h1000, 32'h600, (i == 0) ? 32'h0 : GP);
		run_case(4'h0, 7'h0, 7'h0, 32'h1008, 32'h600, GP);
		run_case(4'h0, 7'h0, 7'h0, 32'h1000, 32'h700, GP);
		final_report();
	end
endmodule : enclave_init_validator_tb
`default_nettype wire
